//--- design/cidr_ctrl.sv
// Control and output side of the caller-identity receiver.
// Assumes analogue tone and bit detectors outside, presenting levels on pins.
`timescale 1ns/1ns
module cidr_ctrl import cidr_pkg::*; (
  input wire logic aclk, // Clock, 125 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic line_amp_output, // Sliced line amplifier signal, a pin.
  input wire logic hybrid_amp_output, // Sliced hybrid amplifier signal, a pin.
  input wire logic demod_bit, // Demodulated data level, a pin.
  input wire logic demod_carrier, // Carrier detector level, a pin.
  input wire logic demod_sample, // Bit sample instant level, a pin.
  input wire logic tone_pair_raw, // Both tones present level, a pin.
  output logic line_amp_en, // Line amplifier enable.
  output logic hybrid_amp_en, // Hybrid amplifier enable.
  output logic demod_en, // Demodulator enable.
  output logic tone_det_en, // Tone detector enable.
  output logic osc_en, // Oscillator enable.
  output logic tone_src_hybrid, // Tone detector fed from hybrid path.
  output logic tone_in, // Selected tone detector input.
  output logic data_out, // Stream data or shifted buffer data.
  output logic bit_strobe, // One-cycle pulse at each data bit sample in stream mode, not at the stop bit.
  output logic byte_end, // One-cycle pulse at the end of each byte in stream mode.
  output logic carrier_present, // Carrier detected.
  output logic shared_ready_or_tone_pin, // Byte ready or tone detected, low true.
  output logic irq // Level interrupt.
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ==========================================================
  // Pin synchronisation
  logic [5:0] pins_s;
  cidr_sync #(.W(6)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({tone_pair_raw, demod_sample, demod_carrier, demod_bit, hybrid_amp_output, line_amp_output}),
    .q(pins_s)
  );
  wire line_s = pins_s[0];
  wire hyb_s = pins_s[1];
  wire bit_s = pins_s[2];
  wire car_s = pins_s[3];
  wire smp_s = pins_s[4];
  wire pair_s = pins_s[5];

  // ==========================================================
  // Mode decode from the select bits
  logic [2:0] ctrl_ff;
  logic [2:0] nxt_ctrl;
  cidr_mode_t mode;
  wire sel_pin_iface = ctrl_ff[CIDR_CTRL_IFACE];
  wire sel_pin_a = ctrl_ff[CIDR_CTRL_SEL_A];
  wire sel_pin_b = ctrl_ff[CIDR_CTRL_SEL_B];
  // Select pins map onto one of six modes; a=b=1 also means data reception.
  always_comb begin
    if (sel_pin_a && !sel_pin_b) begin
      mode = CIDR_M_TONE_HYB;
    end else if (!sel_pin_a && sel_pin_b) begin
      mode = CIDR_M_TONE_LINE;
    end else if (!sel_pin_a && !sel_pin_b) begin
      mode = sel_pin_iface ? CIDR_M_POWER_DOWN : CIDR_M_FACTORY;
    end else begin
      mode = sel_pin_iface ? CIDR_M_FSK_BUFFER : CIDR_M_FSK_STREAM;
    end
  end
  wire is_tone = (mode == CIDR_M_TONE_HYB) || (mode == CIDR_M_TONE_LINE);
  wire is_fsk = (mode == CIDR_M_FSK_STREAM) || (mode == CIDR_M_FSK_BUFFER);
  wire is_buf = (mode == CIDR_M_FSK_BUFFER);

  // ==========================================================
  // Power management and input path selection
  assign osc_en = (mode != CIDR_M_POWER_DOWN);
  assign demod_en = is_fsk;
  assign tone_det_en = is_tone;
  assign line_amp_en = is_fsk || (mode == CIDR_M_TONE_LINE);
  assign hybrid_amp_en = (mode == CIDR_M_TONE_HYB);
  assign tone_src_hybrid = (mode == CIDR_M_TONE_HYB);
  // Unselected amplifier is never looked at.
  assign tone_in = tone_src_hybrid ? hyb_s : (mode == CIDR_M_TONE_LINE) && line_s;

  // ==========================================================
  // Demodulated bit framing
  logic smp_d_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic [7:0] byte_buf_ff;
  logic stop_buf_ff;
  logic ready_ff;
  logic [3:0] out_idx_ff;
  logic bit_strobe_ff;
  logic byte_end_ff;
  logic data_ff;
  wire fsk_live = is_fsk && car_s;
  wire smp_rise = smp_s && !smp_d_ff;
  // Bit counter 0..7 data, 8 stop; only counts with carrier present.
  wire take_bit = fsk_live && smp_rise;
  wire stop_now = take_bit && (bit_cnt_ff == 4'h8);
  wire [3:0] nxt_cnt = !fsk_live ? 4'h0 : (stop_now ? 4'h0 : (take_bit ? bit_cnt_ff + 4'h1 : bit_cnt_ff));

  // Software read of the data register shifts one bit out of the buffer.
  logic shift_req;
  wire shift_do = shift_req && ready_ff && is_buf;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_d_ff <= 1'b0;
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      byte_buf_ff <= 8'h00;
      stop_buf_ff <= 1'b0;
      ready_ff <= 1'b0;
      out_idx_ff <= 4'h0;
      bit_strobe_ff <= 1'b0;
      byte_end_ff <= 1'b0;
      data_ff <= 1'b1;
    end else begin
      smp_d_ff <= smp_s;
      bit_cnt_ff <= nxt_cnt;
      bit_strobe_ff <= take_bit && !is_buf && (bit_cnt_ff < 4'h8);
      byte_end_ff <= stop_now && !is_buf;
      if (take_bit && bit_cnt_ff < 4'h8) begin
        shreg_ff <= {bit_s, shreg_ff[7:1]};
      end
      // Buffer mode keeps byte plus stop bit, new byte wins over shifting.
      if (stop_now && is_buf) begin
        byte_buf_ff <= shreg_ff;
        stop_buf_ff <= bit_s;
        ready_ff <= 1'b1;
        out_idx_ff <= 4'h0;
      end else if (shift_do) begin
        out_idx_ff <= out_idx_ff + 4'h1;
        if (out_idx_ff == 4'h8) begin
          ready_ff <= 1'b0;
        end
      end else if (!is_buf) begin
        ready_ff <= 1'b0;
      end
      // Stream mode passes bits straight out; idle mark when no carrier.
      if (!is_buf) begin
        data_ff <= fsk_live ? bit_s : 1'b1;
      end else if (!car_s) begin
        data_ff <= 1'b1;
      end else if (shift_do) begin
        data_ff <= (out_idx_ff == 4'h8) ? stop_buf_ff : byte_buf_ff[out_idx_ff[2:0]];
      end
    end
  end
  assign data_out = data_ff;
  assign bit_strobe = bit_strobe_ff;
  assign byte_end = byte_end_ff;
  assign carrier_present = fsk_live;

  // ==========================================================
  // Tone-detected output: follows the qualified tone pair.
  logic tone_det_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_det_ff <= 1'b0;
    end else begin
      tone_det_ff <= is_tone && pair_s;
    end
  end
  // Shared pin: tone indicator in tone modes, byte ready otherwise.
  assign shared_ready_or_tone_pin = is_tone ? !tone_det_ff : !(ready_ff && is_fsk);

  // ==========================================================
  // AXI4-Lite slave
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [CIDR_IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic tone_prev_ff;
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire wr_go = (aw_got_ff || aw_hs) && (w_got_ff || w_hs);
  wire [7:0] wa = aw_hs ? s_axi_awaddr : awaddr_ff;
  wire [31:0] wd = w_hs ? s_axi_wdata : wdata_ff;
  wire wr_ok = (wa == CIDR_REG_CTRL) || (wa == CIDR_REG_IRQ_STAT) || (wa == CIDR_REG_IRQ_MASK);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  assign shift_req = ar_hs && (s_axi_araddr == CIDR_REG_DATA);
  wire [CIDR_IRQ_W-1:0] events = {tone_prev_ff && !tone_det_ff, !tone_prev_ff && tone_det_ff, stop_now && is_buf};
  wire [CIDR_IRQ_W-1:0] w1c = (wr_go && wa == CIDR_REG_IRQ_STAT && s_axi_wstrb[0]) ? wd[CIDR_IRQ_W-1:0] : '0;
  assign nxt_ctrl = (wr_go && wa == CIDR_REG_CTRL && s_axi_wstrb[0]) ? wd[2:0] : ctrl_ff;
  // Read data mux.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      CIDR_REG_CTRL: rd_mux = {29'h0, ctrl_ff};
      CIDR_REG_STATUS: rd_mux = {26'h0, tone_det_ff, ready_ff, car_s, is_buf, is_tone, osc_en};
      CIDR_REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
      CIDR_REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
      CIDR_REG_DATA: rd_mux = {22'h0, stop_buf_ff, byte_buf_ff, data_ff};
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_ok = (s_axi_araddr <= CIDR_REG_DATA) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      rdata_ff <= 32'h0;
      bresp_ff <= RESP_OK;
      rresp_ff <= RESP_OK;
      ctrl_ff <= CIDR_CTRL_RST;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      tone_prev_ff <= 1'b0;
    end else begin
      tone_prev_ff <= tone_det_ff;
      ctrl_ff <= nxt_ctrl;
      // Set wins over a same-cycle write-one clear.
      irq_stat_ff <= (irq_stat_ff & ~w1c) | events;
      if (wr_go && wa == CIDR_REG_IRQ_MASK && s_axi_wstrb[0]) begin
        irq_mask_ff <= wd[CIDR_IRQ_W-1:0];
      end
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? RESP_OK : RESP_ERR;
      end else begin
        aw_got_ff <= aw_got_ff | aw_hs;
        w_got_ff <= w_got_ff | w_hs;
        if (s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ==========================================================
  // Checks
  chk_pd_all_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == CIDR_M_POWER_DOWN) |-> !(osc_en || demod_en || tone_det_en || line_amp_en || hybrid_amp_en))
    else $error("power down left a section on");
  chk_fsk_tone_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(demod_en && tone_det_en)) else $error("demodulator and tone detector both on");
  chk_no_carrier_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!is_buf && !fsk_live) |=> data_out) else $error("data passed without carrier");
  chk_tone_pin_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_tone && pair_s) ##1 is_tone |-> !shared_ready_or_tone_pin) else $error("tone not shown");
  chk_ready_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_buf && stop_now) |=> (is_fsk |-> !shared_ready_or_tone_pin)) else $error("byte ready missing");
  chk_byte_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop_now && !is_buf) |=> byte_end) else $error("end of byte strobe missing");
  chk_hyb_path: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_pin_a && !sel_pin_b) |-> (tone_src_hybrid && !line_amp_en)) else $error("hybrid path not chosen");
  chk_stop_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_buf && stop_now) |=> (stop_buf_ff == $past(bit_s))) else $error("stop bit not kept");
endmodule // cidr_ctrl

//--- design/cidr_pkg.sv
// Constants shared by the caller-identity receiver control block.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
//
// What this block does
// - Data demodulation always uses the line input, while tone detection uses the line or hybrid input by mode.
// - The amplifier output that is not selected is ignored.
// - Buffer mode holds each received byte plus its following stop bit, and the stop bit shifts out after the byte.
// - Bit stream mode outputs bits directly with a bit-sample strobe and an end-of-byte strobe.
// - A carrier-present flag is given, and outgoing data is suppressed while no carrier is present.
// - Full power down disables both amplifiers, the demodulator, the tone detector and the oscillator.
// - Selecting data reception powers down the tone detector, and selecting tone detection powers down the demodulator.
// - With tone detection selected, the shared output pin is the active-low tone-detected indicator.
// - The tone-detected output goes low once a valid tone pair is recognised and high again after it ends.
// - Select pins: iface high with a and b low is power down, all low is factory test, with a and b both high iface picks the data mode.
// - Pin a high with b low detects tones on the hybrid path, pin a low with b high on the line path.
package cidr_pkg;

  // Register byte addresses.
  localparam logic [7:0] CIDR_REG_CTRL = 8'h00;
  localparam logic [7:0] CIDR_REG_STATUS = 8'h04;
  localparam logic [7:0] CIDR_REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] CIDR_REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] CIDR_REG_DATA = 8'h10;

  // Control register fields.
  localparam int CIDR_CTRL_IFACE = 0;
  localparam int CIDR_CTRL_SEL_A = 1;
  localparam int CIDR_CTRL_SEL_B = 2;
  localparam int CIDR_CTRL_SHIFT = 3;
  localparam logic [2:0] CIDR_CTRL_RST = 3'h1;

  // Status and interrupt field positions.
  localparam int CIDR_IRQ_BYTE = 0;
  localparam int CIDR_IRQ_TONE_ON = 1;
  localparam int CIDR_IRQ_TONE_OFF = 2;
  localparam int CIDR_IRQ_W = 3;

  // Modes decoded from the three select bits.
  typedef enum logic [5:0] {
    CIDR_M_FSK_STREAM = 6'h01,
    CIDR_M_FSK_BUFFER = 6'h02,
    CIDR_M_TONE_HYB = 6'h04,
    CIDR_M_TONE_LINE = 6'h08,
    CIDR_M_POWER_DOWN = 6'h10,
    CIDR_M_FACTORY = 6'h20
  } cidr_mode_t;

endpackage

//--- design/cidr_sync.sv
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/1ns
module cidr_sync #(
  parameter int W = 1
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [W-1:0] d, // Asynchronous input.
  output logic [W-1:0] q // Synchronised output.
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // cidr_sync

//--- sim/cidr_fe_model.sv
// Model of the analogue front end that feeds the receiver control block.
// Assumes the bench calls its tasks and that it shares aclk with the block.
`timescale 1ns/1ns
module cidr_fe_model (
  input wire logic aclk, // Clock.
  output logic line_amp_output, // Line path slice.
  output logic hybrid_amp_output, // Hybrid path slice.
  output logic demod_bit, // Demodulated data level.
  output logic demod_carrier, // Carrier level.
  output logic demod_sample, // Sample instant level.
  output logic tone_pair_raw // Both tones present.
);
  // All lines start quiet.
  initial begin
    line_amp_output = 1'b0;
    hybrid_amp_output = 1'b0;
    demod_bit = 1'b0;
    demod_carrier = 1'b0;
    demod_sample = 1'b0;
    tone_pair_raw = 1'b0;
  end

  // Without carrier the data line carries noise, so it toggles to expose any leak.
  always @(posedge aclk) begin
    if (!demod_carrier) begin
      demod_bit <= ~demod_bit;
    end
  end

  // Sends nine bits LSB first under carrier, one sample pulse per bit; carrier stays up.
  task automatic send_frame(input logic [8:0] f);
    @(posedge aclk);
    demod_carrier <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      demod_bit <= f[i];
      repeat (4) @(posedge aclk);
      demod_sample <= 1'b1;
      repeat (4) @(posedge aclk);
      demod_sample <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask

  // Ends the carrier.
  task automatic drop_carrier();
    @(posedge aclk);
    demod_carrier <= 1'b0;
  endtask

  // Sets the tone pair and both path levels.
  task automatic set_tone(input logic on, input logic hyb, input logic line);
    @(posedge aclk);
    tone_pair_raw <= on;
    hybrid_amp_output <= hyb;
    line_amp_output <= line;
  endtask
endmodule // cidr_fe_model

//--- sim/testbench.sv
// Self-checking bench for the receiver control block.
// Assumes the front-end model and buffer mode selected by the iface bit high.
`timescale 1ns/1ns
module testbench import cidr_pkg::*; ;
  localparam logic BUF_IFACE = 1'b1; // Interface bit value that selects buffer mode.
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic line_amp_output, hybrid_amp_output, demod_bit, demod_carrier, demod_sample, tone_pair_raw;
  logic line_amp_en, hybrid_amp_en, demod_en, tone_det_en, osc_en, tone_src_hybrid, tone_in, data_out;
  logic bit_strobe, byte_end, carrier_present, shared_ready_or_tone_pin, irq;
  int err_total, compares, strobe_cnt, end_cnt;

  cidr_ctrl cidr_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_amp_output,
    .hybrid_amp_output, .demod_bit, .demod_carrier, .demod_sample, .tone_pair_raw, .line_amp_en, .hybrid_amp_en,
    .demod_en, .tone_det_en, .osc_en, .tone_src_hybrid, .tone_in, .data_out, .bit_strobe, .byte_end,
    .carrier_present, .shared_ready_or_tone_pin, .irq);
  cidr_fe_model cidr_fe_model_inst (.aclk, .line_amp_output, .hybrid_amp_output, .demod_bit, .demod_carrier,
    .demod_sample, .tone_pair_raw);

  // ==========================================================================
  // Clock, watchdog and stream monitor
  // ==========================================================================
  // The clock runs at 125 MHz.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // The whole run needs a few hundred cycles, so 25000 means a hang.
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  // Collects stream bits at each strobe, away from the clock edge.
  always @(negedge aclk) begin
    if (bit_strobe === 1'b1) begin
      strobe_cnt++;
      rx_byte = {data_out, rx_byte[7:1]};
    end
    if (byte_end === 1'b1) end_cnt++;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (6) @(negedge aclk);
  endtask

  // Handshakes are judged at the negative edge, where they equal what the next rising edge takes.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Expected {line, hybrid, demod, tone, osc, tone source} per select value {b, a, iface}.
  function automatic logic [5:0] mode_exp(input logic [2:0] s);
    case (s[2:1])
      2'b00: mode_exp = s[0] ? 6'h00 : 6'h02;
      2'b01: mode_exp = 6'h17;
      2'b10: mode_exp = 6'h26;
      default: mode_exp = 6'h2a;
    endcase
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    logic [31:0] d;
    axi_rd(CIDR_REG_CTRL, d, rsp);
    chk(d, 32'h1);
    chk({line_amp_en, hybrid_amp_en, demod_en, tone_det_en, osc_en, tone_src_hybrid, shared_ready_or_tone_pin, irq}, 8'h02);
    axi_rd(8'h20, d, rsp);
    chk(rsp, 2'h2);
    axi_wr(8'h20, 32'h0, rsp);
    chk(rsp, 2'h2);
  endtask

  task automatic t_modes();
    logic [31:0] d;
    for (int s = 0; s < 8; s++) begin
      axi_wr(CIDR_REG_CTRL, 32'(s), rsp);
      axi_rd(CIDR_REG_CTRL, d, rsp);
      chk(d, 32'(s));
      @(negedge aclk);
      chk({line_amp_en, hybrid_amp_en, demod_en, tone_det_en, osc_en, tone_src_hybrid}, mode_exp(3'(s)));
    end
  endtask

  task automatic t_tone(input logic hyb);
    logic [31:0] d;
    axi_wr(CIDR_REG_CTRL, hyb ? 32'h2 : 32'h4, rsp);
    axi_wr(CIDR_REG_IRQ_MASK, 32'h2, rsp);
    cidr_fe_model_inst.set_tone(1'b0, hyb, !hyb);
    settle();
    chk(tone_in, 1'b1);
    cidr_fe_model_inst.set_tone(1'b1, !hyb, hyb);
    settle();
    chk(tone_in, 1'b0);
    chk({shared_ready_or_tone_pin, irq}, 2'b01);
    cidr_fe_model_inst.set_tone(1'b0, !hyb, hyb);
    settle();
    chk({shared_ready_or_tone_pin, irq}, 2'b11);
    axi_wr(CIDR_REG_IRQ_STAT, 32'h2, rsp);
    axi_rd(CIDR_REG_IRQ_STAT, d, rsp);
    chk(d, 32'h4);
    chk(irq, 1'b0);
    axi_wr(CIDR_REG_IRQ_STAT, 32'h4, rsp);
  endtask

  task automatic t_stream();
    axi_wr(CIDR_REG_CTRL, {29'h0, 2'b11, !BUF_IFACE}, rsp);
    settle();
    chk({data_out, carrier_present}, 2'b10);
    @(negedge aclk);
    chk({data_out, carrier_present}, 2'b10);
    strobe_cnt = 0;
    end_cnt = 0;
    cidr_fe_model_inst.send_frame(9'h1a5);
    settle();
    chk(rx_byte, 8'ha5);
    chk({strobe_cnt[3:0], end_cnt[3:0]}, 8'h81);
    chk(carrier_present, 1'b1);
    cidr_fe_model_inst.drop_carrier();
    settle();
  endtask

  task automatic t_buffer(input logic [8:0] f);
    logic [31:0] d;
    axi_wr(CIDR_REG_CTRL, {29'h0, 2'b11, BUF_IFACE}, rsp);
    axi_wr(CIDR_REG_IRQ_MASK, 32'h1, rsp);
    cidr_fe_model_inst.send_frame(f);
    settle();
    chk({shared_ready_or_tone_pin, irq}, 2'b01);
    // Read data holds the output bit from before that read's shift; the pin shows the new bit.
    for (int k = 0; k < 9; k++) begin
      axi_rd(CIDR_REG_DATA, d, rsp);
      @(negedge aclk);
      if (k == 0) chk(d[9:1], f);
      chk(d[0], (k == 0) ? 1'b1 : f[k - 1]);
      chk(data_out, f[k]);
    end
    @(negedge aclk);
    chk(shared_ready_or_tone_pin, 1'b1);
    axi_wr(CIDR_REG_IRQ_STAT, 32'h1, rsp);
    @(negedge aclk);
    chk(irq, 1'b0);
    cidr_fe_model_inst.drop_carrier();
    settle();
  endtask

  // Main sequence: every input quiet at time zero, reset for 16 cycles, then the scenarios.
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_tone(1'b1);
    t_tone(1'b0);
    t_stream();
    t_buffer(9'h13c);
    t_buffer(9'h0c5);
    end_of_test();
  end
endmodule // testbench
